// ---- core/alu_core.sv ----
// alu datapath with general register file, condition flags and apb register access
//
// Summary of operation
// - signed divide 16/8 and 32/16, quotient plus remainder
// - compare subtracts source from destination, sets flags
// - negate replaces register with zero minus it
// - zero extension fills upper half with zeros
// - sign extension copies low half sign upward
// - test-and-set flags byte minus zero, sets bit 7
// - and, or, xor with register or immediate
// - not writes one's complement back
// - arithmetic shifts by one or two, right shift keeps sign
// - logical shifts by one or two, zero fill
// - rotates by one or two without carry
// - rotates through carry as an extra bit
// - bit set, clear, invert on byte operand
// - bit test loads zero flag with inverted bit
// - carry and/or with selected bit into carry
// - inverted-bit carry ops use immediate bit index
// - size codes byte/word/long; bit ops byte, extend word/long
// - register file: 8-bit, 16-bit and 32-bit overlaid views
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.svh"

module alu_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // operand views of one 32-bit register: sel picks low byte / upper word
  function automatic logic [31:0] view_get(input logic [31:0] er, input logic sel,
                                           input alu_pkg::alu_size_e sz);
    case (sz)
      alu_pkg::size_byte: view_get = sel ? {24'h0, er[7:0]} : {24'h0, er[15:8]};
      alu_pkg::size_word: view_get = sel ? {16'h0, er[31:16]} : {16'h0, er[15:0]};
      default: view_get = er;
    endcase
  endfunction

  // merge a result into the view it came from, leaving the rest of the register
  function automatic logic [31:0] view_put(input logic [31:0] er, input logic sel,
                                           input alu_pkg::alu_size_e sz, input logic [31:0] v);
    case (sz)
      alu_pkg::size_byte: view_put = sel ? {er[31:8], v[7:0]} : {er[31:16], v[7:0], er[7:0]};
      alu_pkg::size_word: view_put = sel ? {v[15:0], er[15:0]} : {er[31:16], v[15:0]};
      default: view_put = v;
    endcase
  endfunction

  function automatic logic [4:0] top_idx(input alu_pkg::alu_size_e sz);
    case (sz)
      alu_pkg::size_byte: top_idx = 5'h07;
      alu_pkg::size_word: top_idx = 5'h0F;
      default: top_idx = 5'h1F;
    endcase
  endfunction

  function automatic logic [31:0] fit(input logic [31:0] v, input alu_pkg::alu_size_e sz);
    case (sz)
      alu_pkg::size_byte: fit = {24'h0, v[7:0]};
      alu_pkg::size_word: fit = {16'h0, v[15:0]};
      default: fit = v;
    endcase
  endfunction

  // negative and zero flags of a result at its size
  function automatic logic [1:0] nz(input logic [31:0] v, input alu_pkg::alu_size_e sz);
    nz = {v[top_idx(sz)], fit(v, sz) == 32'h0};
  endfunction

  // a - b at size: returns {n, z, v, c, difference}
  function automatic logic [35:0] sub_f(input logic [31:0] a, input logic [31:0] b,
                                       input alu_pkg::alu_size_e sz);
    logic [31:0] d;
    logic [4:0] t;
    d = fit(a - b, sz);
    t = top_idx(sz);
    sub_f = {nz(d, sz), (a[t] ^ b[t]) & (a[t] ^ d[t]), fit(a, sz) < fit(b, sz), d};
  endfunction

  // one shift or rotate step: returns {overflow, carry out, value}
  function automatic logic [33:0] step(input alu_pkg::alu_op_e op, input alu_pkg::alu_size_e sz,
                                       input logic [31:0] v, input logic c);
    logic [4:0] t;
    logic fill;
    logic [31:0] r;
    t = top_idx(sz);
    if (op == alu_pkg::arith_shift_left || op == alu_pkg::logic_shift_left ||
        op == alu_pkg::rotate_left || op == alu_pkg::rotate_carry_left) begin
      fill = (op == alu_pkg::rotate_left) ? v[t] : (op == alu_pkg::rotate_carry_left) & c;
      r = fit({v[30:0], fill}, sz);
      step = {(op == alu_pkg::arith_shift_left) & (v[t] ^ r[t]), v[t], r};
    end else begin
      fill = (op == alu_pkg::arith_shift_right) ? v[t] :
             (op == alu_pkg::rotate_right) ? v[0] :
             (op == alu_pkg::rotate_carry_right) & c;
      r = fit(v, sz) >> 1;
      r[t] = fill;
      step = {1'b0, v[0], r};
    end
  endfunction

  // general registers: eight longwords that also serve the word and byte views
  logic [31:0] gr [8];
  logic [31:0] ctrl;
  logic [31:0] imm;
  logic [3:0] flags;
  logic [7:0] memb;
  logic stat_dz;
  logic stat_bad;
  alu_pkg::alu_state_e state;
  alu_pkg::alu_state_e next_state;

  // divider working state
  logic [31:0] dv_quo;
  logic [16:0] dv_rem;
  logic [15:0] dv_dvs;
  logic [4:0] dv_cnt;
  logic dv_byte;
  logic dv_qneg;
  logic dv_rneg;
  logic [3:0] dv_dst;

  // apb decode; writes stall while a divide is running so the register file has one writer
  wire busy = (state == alu_pkg::st_div);
  wire a_ctrl = paddr == `ALU_OFS_CTRL;
  wire a_imm = paddr == `ALU_OFS_IMM;
  wire a_flags = paddr == `ALU_OFS_FLAGS;
  wire a_memb = paddr == `ALU_OFS_MEMB;
  wire a_stat = paddr == `ALU_OFS_STAT;
  wire a_gr = (paddr[7:5] == `ALU_GR_PAGE) && (paddr[1:0] == 2'h0);
  wire mapped = a_ctrl | a_imm | a_flags | a_memb | a_stat | a_gr;
  wire wr_go = psel & penable & pwrite & pready & mapped;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire exec_go = wr_go & a_ctrl;
  assign pready = ~(busy & pwrite);
  assign pslverr = psel & penable & ~mapped;

  // command fields come straight from the write data of the launching write
  wire alu_pkg::alu_op_e c_op = alu_pkg::alu_op_e'(pwdata[`ALU_F_OP_LSB +: 5]);
  wire alu_pkg::alu_size_e c_sz = alu_pkg::alu_size_e'(pwdata[`ALU_F_SIZE_LSB +: 2]);
  wire [3:0] c_dst = pwdata[`ALU_F_DST_LSB +: 4];
  wire [3:0] c_src = pwdata[`ALU_F_SRC_LSB +: 4];
  wire c_bitop = c_op >= alu_pkg::bit_set_op;
  wire c_invop = (c_op == alu_pkg::carry_and_notbit_op) || (c_op == alu_pkg::carry_or_notbit_op);
  wire alu_pkg::alu_size_e c_eff = c_bitop ? alu_pkg::size_byte : c_sz;

  // operand selection
  wire [31:0] er_dst = gr[c_dst[2:0]];
  wire [31:0] er_src = gr[c_src[2:0]];
  wire [31:0] op_a = view_get(er_dst, c_dst[3], c_eff);
  wire [31:0] op_b = pwdata[`ALU_F_USE_IMM] ? fit(imm, c_eff) :
                     view_get(er_src, c_src[3], c_eff);
  wire [31:0] bit_src_full = view_get(er_src, c_src[3], alu_pkg::size_byte);
  wire [7:0] bit_src = bit_src_full[7:0];
  wire [7:0] bit_opd = pwdata[`ALU_F_MEM] ? memb : op_a[7:0];
  // inverted-bit carry forms always take the immediate index
  wire [2:0] bit_idx = (pwdata[`ALU_F_BIT_REG] & ~c_invop) ? bit_src[2:0] :
                       pwdata[`ALU_F_BIT_LSB +: 3];
  wire [7:0] bit_msk = 8'h01 << bit_idx;
  wire bit_val = bit_opd[bit_idx];
  wire tset_reg_ok = (c_dst[2:0] == 3'h0) || (c_dst[2:0] == 3'h1) ||
                    (c_dst[2:0] == 3'h4) || (c_dst[2:0] == 3'h5);

  // shift and rotate, one or two steps
  wire [33:0] sh1 = step(c_op, c_eff, op_a, flags[`ALU_FLG_C]);
  wire [33:0] sh2 = step(c_op, c_eff, sh1[31:0], sh1[32]);
  wire [33:0] shr = pwdata[`ALU_F_BY2] ? {sh1[33] | sh2[33], sh2[32:0]} : sh1;

  // divider start operands, sign handled apart from the magnitude loop
  wire alu_pkg::alu_size_e dvd_sz = (c_sz == alu_pkg::size_byte) ? alu_pkg::size_word :
                                    alu_pkg::size_long;
  wire [31:0] dvd_raw = view_get(er_dst, c_dst[3], dvd_sz);
  wire [31:0] dvd_s = (c_sz == alu_pkg::size_byte) ? {{16{dvd_raw[15]}}, dvd_raw[15:0]} : dvd_raw;
  wire [31:0] dvd_mag = dvd_s[31] ? 32'h0 - dvd_s : dvd_s;
  wire alu_pkg::alu_size_e dvs_sz = (c_sz == alu_pkg::size_byte) ? alu_pkg::size_byte :
                                    alu_pkg::size_word;
  wire [31:0] dvs_full = view_get(er_src, c_src[3], dvs_sz);
  wire [15:0] dvs_raw = dvs_full[15:0];
  wire dvs_neg = (c_sz == alu_pkg::size_byte) ? dvs_raw[7] : dvs_raw[15];
  wire [15:0] dvs_s = (c_sz == alu_pkg::size_byte) ? {{8{dvs_raw[7]}}, dvs_raw[7:0]} : dvs_raw;
  wire [15:0] dvs_mag = dvs_neg ? 16'h0 - dvs_s : dvs_s;

  // execute: single-cycle operations resolve here; divide only starts
  logic [31:0] ex_res;
  logic [3:0] ex_flags;
  logic [7:0] ex_memb;
  logic ex_wreg;
  logic ex_bad;
  logic ex_dz;
  logic ex_div;
  logic [35:0] sx;
  always_comb begin
    ex_res = op_a;
    ex_flags = flags;
    ex_memb = memb;
    ex_wreg = 1'b0;
    ex_bad = 1'b0;
    ex_dz = 1'b0;
    ex_div = 1'b0;
    sx = 36'h0;
    case (c_op)
      alu_pkg::signed_divide_op: begin
        if (c_sz == alu_pkg::size_long) begin
          ex_bad = 1'b1;
        end else if (dvs_mag == 16'h0) begin
          ex_dz = 1'b1;
          ex_flags[`ALU_FLG_Z] = 1'b1;
        end else begin
          ex_div = 1'b1;
        end
      end
      alu_pkg::compare_op: begin
        sx = sub_f(op_a, op_b, c_eff);
        ex_flags = sx[35:32];
      end
      alu_pkg::twos_complement_op: begin
        sx = sub_f(32'h0, op_a, c_eff);
        ex_flags = sx[35:32];
        ex_res = sx[31:0];
        ex_wreg = 1'b1;
      end
      alu_pkg::zero_extend_op, alu_pkg::sign_widen_op: begin
        if (c_sz == alu_pkg::size_byte) begin
          ex_bad = 1'b1;
        end else begin
          if (c_sz == alu_pkg::size_word) begin
            ex_res = (c_op == alu_pkg::zero_extend_op) ? {24'h0, op_a[7:0]} :
                     {16'h0, {8{op_a[7]}}, op_a[7:0]};
          end else begin
            ex_res = (c_op == alu_pkg::zero_extend_op) ? {16'h0, op_a[15:0]} :
                     {{16{op_a[15]}}, op_a[15:0]};
          end
          ex_flags[`ALU_FLG_N:`ALU_FLG_V] = {nz(ex_res, c_sz), 1'b0};
          ex_wreg = 1'b1;
        end
      end
      alu_pkg::test_and_set_op: begin
        if (!tset_reg_ok) begin
          ex_bad = 1'b1;
        end else begin
          sx = sub_f({24'h0, memb}, 32'h0, alu_pkg::size_byte);
          ex_flags[`ALU_FLG_N:`ALU_FLG_V] = {sx[35:34], 1'b0};
          ex_memb = memb | `ALU_TSET_MASK;
        end
      end
      alu_pkg::and_op, alu_pkg::or_op, alu_pkg::xor_op, alu_pkg::not_op: begin
        ex_res = (c_op == alu_pkg::and_op) ? op_a & op_b :
                 (c_op == alu_pkg::or_op) ? op_a | op_b :
                 (c_op == alu_pkg::xor_op) ? op_a ^ op_b :
                 fit(~op_a, c_eff);
        ex_flags[`ALU_FLG_N:`ALU_FLG_V] = {nz(ex_res, c_eff), 1'b0};
        ex_wreg = 1'b1;
      end
      alu_pkg::bit_set_op, alu_pkg::bit_clear_op, alu_pkg::bit_invert_op: begin
        ex_res = {24'h0, (c_op == alu_pkg::bit_set_op) ? bit_opd | bit_msk :
                         (c_op == alu_pkg::bit_clear_op) ? bit_opd & ~bit_msk :
                         bit_opd ^ bit_msk};
        ex_wreg = ~pwdata[`ALU_F_MEM];
        ex_memb = pwdata[`ALU_F_MEM] ? ex_res[7:0] : memb;
      end
      alu_pkg::bit_test_op: ex_flags[`ALU_FLG_Z] = ~bit_val;
      alu_pkg::carry_and_bit_op: ex_flags[`ALU_FLG_C] = flags[`ALU_FLG_C] & bit_val;
      alu_pkg::carry_and_notbit_op: ex_flags[`ALU_FLG_C] = flags[`ALU_FLG_C] & ~bit_val;
      alu_pkg::carry_or_bit_op: ex_flags[`ALU_FLG_C] = flags[`ALU_FLG_C] | bit_val;
      alu_pkg::carry_or_notbit_op: ex_flags[`ALU_FLG_C] = flags[`ALU_FLG_C] | ~bit_val;
      default: begin
        // shifts and rotates
        ex_res = shr[31:0];
        ex_flags = {nz(shr[31:0], c_eff), shr[33], shr[32]};
        ex_wreg = 1'b1;
      end
    endcase
  end

  // restoring divide step on magnitudes, one quotient bit per clock
  wire [16:0] dv_shift = {dv_rem[15:0], dv_quo[31]};
  wire dv_ge = dv_shift >= {1'b0, dv_dvs};
  wire [16:0] next_rem = dv_ge ? dv_shift - {1'b0, dv_dvs} : dv_shift;
  wire [31:0] next_quo = {dv_quo[30:0], dv_ge};
  wire dv_last = dv_cnt == (dv_byte ? `ALU_DIV_LAST_B : `ALU_DIV_LAST_W);
  wire dv_done = busy & dv_last;
  // quotient overflow is not detected; its result is undefined, as for the cpu
  wire [15:0] q_mag = dv_byte ? {8'h0, next_quo[7:0]} : next_quo[15:0];
  wire [15:0] q_out = dv_qneg ? 16'h0 - q_mag : q_mag;
  wire [15:0] r_out = dv_rneg ? 16'h0 - next_rem[15:0] : next_rem[15:0];
  wire [31:0] dv_wd = dv_byte ? view_put(gr[dv_dst[2:0]], dv_dst[3], alu_pkg::size_word,
                                         {16'h0, r_out[7:0], q_out[7:0]}) :
                      {r_out, q_out};
  wire dv_n = dv_byte ? q_out[7] : q_out[15];

  // one register-file write port shared by divider, execute and the bus
  wire gr_we = dv_done | (exec_go & ex_wreg) | (wr_go & a_gr);
  wire [2:0] gr_wi = dv_done ? dv_dst[2:0] : exec_go ? c_dst[2:0] : paddr[4:2];
  wire [31:0] gr_wd = dv_done ? dv_wd :
                      exec_go ? view_put(er_dst, c_dst[3], c_eff, ex_res) : pwdata;

  assign next_state = ((state == alu_pkg::st_idle) && exec_go && ex_div) ? alu_pkg::st_div :
                      dv_done ? alu_pkg::st_idle : state;

  // read mux, sampled in the setup phase so prdata comes from a flip-flop
  wire [31:0] rd_mux = a_ctrl ? ctrl : a_imm ? imm : a_flags ? {28'h0, flags} :
                       a_memb ? {24'h0, memb} :
                       a_stat ? {29'h0, stat_bad, stat_dz, busy} :
                       a_gr ? gr[paddr[4:2]] : `ALU_RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) gr[i] <= `ALU_RST_WORD;
    end else if (gr_we) begin
      gr[gr_wi] <= gr_wd;
    end
  end

  // software-visible control and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ALU_RST_WORD;
      imm <= `ALU_RST_WORD;
      flags <= `ALU_RST_FLAGS;
      memb <= `ALU_RST_BYTE;
      stat_dz <= 1'b0;
      stat_bad <= 1'b0;
      prdata <= `ALU_RST_WORD;
      state <= alu_pkg::st_idle;
    end else begin
      state <= next_state;
      if (rd_setup) prdata <= rd_mux;
      if (wr_go & a_ctrl) ctrl <= pwdata;
      if (wr_go & a_imm) imm <= pwdata;
      if (wr_go & a_memb) memb <= pwdata[7:0];
      else if (exec_go) memb <= ex_memb;
      if (dv_done) flags[`ALU_FLG_N:`ALU_FLG_Z] <= {dv_n, 1'b0};
      else if (exec_go) flags <= ex_flags;
      else if (wr_go & a_flags) flags <= pwdata[3:0];
      if (exec_go) begin
        stat_dz <= ex_dz;
        stat_bad <= ex_bad;
      end
    end
  end

  // divider registers load on launch and step while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_quo <= `ALU_RST_WORD;
      dv_rem <= 17'h0;
      dv_dvs <= 16'h0;
      dv_cnt <= 5'h0;
      dv_byte <= 1'b0;
      dv_qneg <= 1'b0;
      dv_rneg <= 1'b0;
      dv_dst <= 4'h0;
    end else if (exec_go & ex_div) begin
      // upper dividend half seeds the remainder, so only quotient bits are stepped
      dv_quo <= (c_sz == alu_pkg::size_byte) ? {dvd_mag[7:0], 24'h0} : {dvd_mag[15:0], 16'h0};
      dv_rem <= (c_sz == alu_pkg::size_byte) ? {9'h0, dvd_mag[15:8]} : {1'b0, dvd_mag[31:16]};
      dv_dvs <= dvs_mag;
      dv_cnt <= 5'h0;
      dv_byte <= c_sz == alu_pkg::size_byte;
      dv_qneg <= dvd_s[31] ^ dvs_neg;
      dv_rneg <= dvd_s[31];
      dv_dst <= c_dst;
    end else if (busy) begin
      dv_quo <= next_quo;
      dv_rem <= next_rem;
      dv_cnt <= dv_cnt + 5'h1;
    end
  end

endmodule // alu_core

`default_nettype wire

// ---- core/alu_defines.svh ----
// register offsets, field positions, flag positions and counts for the alu datapath
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

`define ALU_OFS_CTRL 8'h00
`define ALU_OFS_IMM 8'h04
`define ALU_OFS_FLAGS 8'h08
`define ALU_OFS_MEMB 8'h0C
`define ALU_OFS_STAT 8'h10
`define ALU_GR_PAGE 3'h1

`define ALU_F_OP_LSB 0
`define ALU_F_SIZE_LSB 5
`define ALU_F_DST_LSB 8
`define ALU_F_SRC_LSB 12
`define ALU_F_USE_IMM 16
`define ALU_F_BIT_LSB 17
`define ALU_F_BIT_REG 20
`define ALU_F_MEM 21
`define ALU_F_BY2 22

`define ALU_FLG_N 3
`define ALU_FLG_Z 2
`define ALU_FLG_V 1
`define ALU_FLG_C 0

`define ALU_ST_BUSY 0
`define ALU_ST_DZ 1
`define ALU_ST_BAD 2

`define ALU_TSET_BIT 7
`define ALU_TSET_MASK 8'h80
`define ALU_DIV_LAST_B 5'h07
`define ALU_DIV_LAST_W 5'h0F
`define ALU_RST_WORD 32'h0000_0000
`define ALU_RST_FLAGS 4'h0
`define ALU_RST_BYTE 8'h00

`endif

// ---- core/alu_pkg.sv ----
// types shared by the alu datapath: operations, operand sizes, sequencer states
package alu_pkg;

  typedef enum logic [4:0] {
    signed_divide_op = 5'h00,
    compare_op = 5'h01,
    twos_complement_op = 5'h02,
    zero_extend_op = 5'h03,
    sign_widen_op = 5'h04,
    test_and_set_op = 5'h05,
    and_op = 5'h06,
    or_op = 5'h07,
    xor_op = 5'h08,
    not_op = 5'h09,
    arith_shift_left = 5'h0A,
    arith_shift_right = 5'h0B,
    logic_shift_left = 5'h0C,
    logic_shift_right = 5'h0D,
    rotate_left = 5'h0E,
    rotate_right = 5'h0F,
    rotate_carry_left = 5'h10,
    rotate_carry_right = 5'h11,
    bit_set_op = 5'h12,
    bit_clear_op = 5'h13,
    bit_invert_op = 5'h14,
    bit_test_op = 5'h15,
    carry_and_bit_op = 5'h16,
    carry_and_notbit_op = 5'h17,
    carry_or_bit_op = 5'h18,
    carry_or_notbit_op = 5'h19
  } alu_op_e;

  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } alu_size_e;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_div = 2'b10
  } alu_state_e;

endpackage

// ---- sim/alu_core_chk.sv ----
// concurrent checks on the apb port of the alu datapath
`timescale 1ns/1ps
`default_nettype none

module alu_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // decoded bus events; the register page only takes aligned words
  wire logic acc = psel && penable;
  wire logic hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}
    || (paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0);
  wire logic cmd = acc && pwrite && pready && paddr == 8'h00;
  sequence s_div_b; cmd && pwdata[6:0] == 7'h00; endsequence
  sequence s_div_w; cmd && pwdata[6:0] == 7'h20; endsequence
  sequence s_quick; cmd && (pwdata[4:0] != 5'h00 || pwdata[6:5] == 2'h2); endsequence
  property p_read_nowait; acc && !pwrite |-> pready; endproperty
  a_read_nowait: assert property (p_read_nowait)
    else $error("read access was stalled");
  property p_unmapped_err; acc && !hit |-> pslverr; endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access without error");
  property p_mapped_ok; acc && hit |-> !pslverr; endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access flagged as error");
  property p_idle_noerr; !acc |-> !pslverr; endproperty
  a_idle_noerr: assert property (p_idle_noerr)
    else $error("error flag outside access phase");
  property p_unmapped_zero; acc && !pwrite && !hit |-> prdata == 32'h0; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned data");
  property p_rdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read setup");
  property p_flags_narrow; acc && !pwrite && paddr == 8'h08 |-> prdata[31:4] == 28'h0; endproperty
  a_flags_narrow: assert property (p_flags_narrow)
    else $error("flag read shows upper bits");
  property p_div_b; s_div_b |-> ##9 pready; endproperty
  a_div_b: assert property (p_div_b)
    else $error("byte divide still busy after eight cycles");
  property p_div_w; s_div_w |-> ##17 pready; endproperty
  a_div_w: assert property (p_div_w)
    else $error("word divide still busy after sixteen cycles");
  property p_quick; s_quick |=> pready [*2]; endproperty
  a_quick: assert property (p_quick)
    else $error("single cycle or refused command left the bus stalled");
  property p_stall_ends; acc && pwrite && !pready |-> ##[1:17] pready; endproperty
  a_stall_ends: assert property (p_stall_ends)
    else $error("write stall outlasted a divide");
endmodule // alu_core_chk

bind alu_core alu_core_chk i_alu_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the alu datapath against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.svh"

module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ill = 0, dz = 0;
  logic [7:0] paddr = 0, mb = 0;
  logic [31:0] pwdata = 0, prdata, im = 0;
  logic pready, pslverr;
  logic [3:0] fl = 0;
  logic [31:0] er [8] = '{default: 32'h0};
  logic [31:0] edge_v [4] = '{32'h0, 32'h8080_8080, 32'hFFFF_FFFF, 32'h7FFF_7F7F};
  int fail_count = 0, compares = 0;
  // 40 MHz bus clock
  always #12.5 pclk = ~pclk;
  alu_core i_alu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the request stands until a rising edge sees pready high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // register views: byte and word halves overlay the long registers
  function automatic int vpos(logic [3:0] i, int s);
    return s == 0 ? (i[3] ? 0 : 8) : ((s == 1 && i[3]) ? 16 : 0);
  endfunction
  function automatic logic [31:0] msk(int s);
    return s >= 2 ? 32'hFFFF_FFFF : (32'h1 << (8 << s)) - 32'h1;
  endfunction
  function automatic logic [31:0] getv(logic [3:0] i, int s);
    return (er[i[2:0]] >> vpos(i, s)) & msk(s);
  endfunction
  task automatic putv(logic [3:0] i, int s, logic [31:0] v);
    er[i[2:0]] = (er[i[2:0]] & ~(msk(s) << vpos(i, s))) | ((v & msk(s)) << vpos(i, s));
  endtask
  task automatic setreg(logic [2:0] n, logic [31:0] v);
    er[n] = v;
    wr({3'h1, n, 2'h0}, v);
  endtask
  // reference model of one command
  task automatic mexec(logic [31:0] c);
    logic [4:0] op;
    int s, w, x, y, q, rm;
    logic [31:0] a, b, m, r, sb;
    logic [7:0] by;
    logic [2:0] bi;
    logic cy, t, v, wb;
    op = c[4:0];
    s = c[6:5];
    w = 8 << s;
    m = msk(s);
    sb = 32'h1 << (w - 1);
    a = getv(c[11:8], s);
    b = c[16] ? im & m : getv(c[15:12], s);
    cy = fl[0];
    v = 1'b0;
    wb = 1'b1;
    dz = 1'b0;
    ill = (op == 0 && s == 2) || (op inside {3, 4} && s == 0)
      || (op == 5 && !(c[10:8] inside {0, 1, 4, 5}));
    if (ill) return;
    case (op)
      0: begin
        a = getv(c[11:8], s + 1);
        x = s ? $signed(a) : $signed(a[15:0]);
        y = s ? $signed(b[15:0]) : $signed(b[7:0]);
        dz = y == 0;
        fl[2] = dz;
        if (!dz) begin
          q = x / y;
          rm = x % y;
          putv(c[11:8], s + 1, s ? {rm[15:0], q[15:0]} : {16'h0, rm[7:0], q[7:0]});
          fl[3] = s ? q[15] : q[7];
        end
        return;
      end
      1, 2: begin
        if (op == 2) b = a;
        if (op == 2) a = 32'h0;
        r = (a - b) & m;
        cy = b > a;
        v = ((a ^ b) & (a ^ r) & sb) != 0;
        wb = op == 2;
      end
      3: r = a & (m >> (w / 2));
      4: r = a[w / 2 - 1] ? a | (m & ~(m >> (w / 2))) : a & (m >> (w / 2));
      5: begin
        fl[3:1] = {mb[7], mb == 8'h0, 1'b0};
        mb = mb | 8'h80;
        return;
      end
      6: r = a & b;
      7: r = a | b;
      8: r = a ^ b;
      9: r = ~a & m;
      10, 11, 12, 13, 14, 15, 16, 17: begin
        r = a;
        for (int j = 0; j < (c[22] ? 2 : 1); j++) begin
          t = op[0] ? r[0] : r[w - 1];
          r = op[0] ? r >> 1 : (r << 1) & m;
          if (op == 10) v = v | (r[w - 1] != t);
          if (op == 11) r = r | ((r << 1) & sb);
          if (op == 14 || op == 16) r = r | (op == 14 ? t : cy);
          if (op == 15 || op == 17) r = r | ((op == 15 ? t : cy) ? sb : 32'h0);
          cy = t;
        end
      end
      default: begin
        by = c[21] ? mb : 8'(getv(c[11:8], 0));
        r = getv(c[15:12], 0);
        bi = (c[20] && op != 23 && op != 25) ? r[2:0] : c[19:17];
        case (op)
          18: by[bi] = 1'b1;
          19: by[bi] = 1'b0;
          20: by[bi] = ~by[bi];
          21: fl[2] = ~by[bi];
          22: fl[0] = fl[0] & by[bi];
          23: fl[0] = fl[0] & ~by[bi];
          24: fl[0] = fl[0] | by[bi];
          default: fl[0] = fl[0] | ~by[bi];
        endcase
        if (c[21]) mb = by;
        else putv(c[11:8], 0, {24'h0, by});
        return;
      end
    endcase
    fl = {r[w - 1], r == 32'h0, v, cy};
    if (wb) putv(c[11:8], s, r);
  endtask
  // read back every register the model tracks
  task automatic chk_all();
    logic [31:0] q;
    logic e;
    for (int n = 0; n < 8; n++) begin
      apb(1'b0, {3'h1, 3'(n), 2'h0}, 32'h0, q, e);
      check(q, er[n]);
    end
    apb(1'b0, `ALU_OFS_FLAGS, 32'h0, q, e);
    check(q, {28'h0, fl});
    apb(1'b0, `ALU_OFS_MEMB, 32'h0, q, e);
    check(q, {24'h0, mb});
  endtask
  // one command; a divide is watched while busy and a write is pushed into its stall
  task automatic run_op(logic [31:0] c);
    logic [31:0] q;
    logic e;
    wr(`ALU_OFS_IMM, im);
    wr(`ALU_OFS_CTRL, c);
    mexec(c);
    if (c[4:0] == 5'h0 && !ill && !dz) begin
      apb(1'b0, `ALU_OFS_STAT, 32'h0, q, e);
      check(q[0], 1'b1);
      wr(`ALU_OFS_IMM, im);
    end
    apb(1'b0, `ALU_OFS_STAT, 32'h0, q, e);
    check(q[2], ill);
    if (c[4:0] == 5'h0 && !ill) check(q[1], dz);
    chk_all();
  endtask
  // reset, preload, then every operation and size with random and edge operands
  initial begin
    logic [31:0] c, q, x;
    logic e;
    void'($urandom(46));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_all();
    for (int n = 0; n < 8; n++) setreg(3'(n), $urandom);
    mb = 8'($urandom);
    wr(`ALU_OFS_MEMB, {24'h0, mb});
    for (int op = 0; op < 26; op++) begin
      for (int s = 0; s < 3; s++) begin
        for (int rep = 0; rep < 3; rep++) begin
          c = ($urandom & 32'h007F_FF00) | 32'(s << 5) | 32'(op);
          im = $urandom;
          fl = 4'($urandom);
          wr(`ALU_OFS_FLAGS, {28'h0, fl});
          if (rep == 0) setreg(c[10:8], edge_v[$urandom_range(3)]);
          if (op == 0) begin
            // small dividends keep the quotient in range; rep 1 divides by zero
            c[16] = 1'b0;
            if (rep == 1) c[14:12] = c[10:8] + 3'h1;
            if (rep == 1) setreg(c[14:12], 32'h0);
            x = $urandom;
            putv(c[11:8], s + 1, s ? {{17{x[14]}}, x[14:0]} : {{25{x[6]}}, x[6:0]});
            setreg(c[10:8], er[c[10:8]]);
          end
          run_op(c);
        end
      end
    end
    // unmapped places answer with an error, read zero and ignore writes
    apb(1'b0, 8'h14, 32'h0, q, e);
    check(q, 32'h0);
    check(e, 1'b1);
    apb(1'b1, 8'h22, 32'hFFFF_FFFF, q, e);
    check(e, 1'b1);
    wr(`ALU_OFS_STAT, 32'hFFFF_FFFF);
    apb(1'b0, `ALU_OFS_STAT, 32'h0, q, e);
    check(q[2], ill);
    chk_all();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
